// [core/msr_cfg.svh]
// Purpose: constants for the memory sync and reservation unit
// Assumes: 32-bit words, 32-byte reservation granule
// Notes:   included by the core only
`ifndef MSR_CFG_SVH
`define MSR_CFG_SVH
`define MSR_GRANULE_BITS     5
`define MSR_WORD_ALIGN_BITS  2
`define MSR_TB_DIV           4
`define MSR_TB_DIV_W         2
`define MSR_BIT25_POS        6
`define MSR_TB_LOW_SEL       1'b0
`define MSR_TB_HIGH_SEL      1'b1
`define MSR_CLK_PERIOD_NS    100
`endif

// [core/msr_pkg.sv]
// Purpose: types for the memory sync and reservation unit
// Assumes: used with msr_cfg.svh
// Notes:   operation codes and carrier structs
package msr_pkg;
    typedef enum logic [3:0] {
        MSR_OP_NONE, MSR_OP_LOAD_RSV, MSR_OP_STORE_COND, MSR_OP_FULL_BAR,
        MSR_OP_IO_BAR, MSR_OP_INSN_SYNC, MSR_OP_READ_TB, MSR_OP_BLOCK_CACHE
    } msr_op_e;
    typedef struct packed {
        msr_op_e     op;
        logic [31:0] addr;
        logic        record_bit;
        logic        tb_half;
        logic [31:0] store_data;
    } msr_req_s;
    typedef struct packed {
        logic [31:0] data;
        logic        cr0_valid;
        logic [3:0]  condition_field_zero;
        logic        align_exc;
        logic        invalid_form;
    } msr_rsp_s;
    typedef enum logic [2:0] {
        MSR_BUS_NONE, MSR_BUS_STORE_COND, MSR_BUS_FULL_BAR, MSR_BUS_IO_BAR, MSR_BUS_BLOCK
    } msr_bus_e;
    typedef struct packed {
        msr_bus_e    kind;
        logic [31:0] addr;
        logic [31:0] data;
        logic        bypass_l2;
    } msr_bus_s;
endpackage

// [core/msr_core.sv]
// Contract
// RULE1 - reservation covers aligned 32-byte region
// RULE2 - write-through page never raises storage exception
// RULE3 - misaligned reserve or conditional store: alignment exception
// RULE4 - only conditional store valid with record bit
// RULE5 - every conditional store makes a bus transaction
// RULE6 - full barrier stalls later work, stops gathering
// RULE7 - full barrier waits earlier cache/bus activity
// RULE8 - broadcast enabled: barrier waits broadcast success
// RULE9 - barrier or reserve with record bit invalid
// RULE10 - time base halves read separately only
// RULE11 - time base counts at quarter bus clock
// RULE12 - decoder ignores instruction bit 25
// RULE13 - user mode may read both halves
// RULE14 - io barrier orders uncached/write-through accesses
// RULE15 - io barrier broadcast only when enabled
// RULE16 - io barrier bypasses L2 to bus unit
// RULE17 - noncacheable accesses never reordered
// RULE18 - no store gathering across io barrier
// RULE19 - insn sync flushes queue, waits, refetches
// RULE20 - insn sync ignores pending store queue
// RULE21 - L2 system performs queued refs before ack
// RULE22 - broadcast bit also broadcasts block cache ops
// RULE23 - conditional store succeeds only with reservation
//
// Purpose: barrier sequencing, reservation and time base for the core
// Assumes: bus clock equals clock; one request at a time, held until done
// Notes:   the pipeline asserts req_valid and waits for done
//          done is a one-cycle pulse; rsp holds until the next request
//          the response register loads every wait cycle, so waits never stale it
//          only the full barrier needs a good bus answer; others end on ack
//          the reservation lives here, not in the cache, so snoops cannot clear it
//          a misaligned reserve or conditional store never reaches the bus
//          the time base has no write path here
//          the opcode word is kept only for trace, with bit 25 masked off
`include "msr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module msr_core
    import msr_pkg::*;
#(
    parameter int GRANULE_BITS = `MSR_GRANULE_BITS
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // request from pipeline
    input  wire logic        req_valid,
    input  wire msr_req_s    req,
    input  wire logic [31:0] insn_word,
    input  wire logic        user_mode,
    input  wire logic        page_write_through,
    // pipeline status
    // levels on the same clock, so no synchroniser stands in front of them
    input  wire logic        older_excp_pending,
    input  wire logic        older_mem_busy,
    input  wire logic        older_io_busy,
    input  wire logic        older_incomplete,
    input  wire logic        broadcast_enable_bit,
    input  wire logic        store_gather_en,
    input  wire logic [31:0] load_data,
    // answer to pipeline
    // handshake outputs are combinational from state, data ones registered
    output logic             done,
    output msr_rsp_s         rsp,
    output logic             stall_younger,
    output logic             gather_block,
    output logic             iq_flush,
    output logic             refetch,
    output logic             rsv_valid,
    output logic [31:0]      rsv_addr,
    output logic [63:0]      time_base,
    // external bus
    output logic             bus_valid,
    output msr_bus_s         bus_req,
    input  wire logic        bus_ack,
    input  wire logic        bus_ok
);
    // refuse granules finer than a word or wider than a page
    if (GRANULE_BITS < `MSR_WORD_ALIGN_BITS || GRANULE_BITS > 12) begin : g_bad_granule
        $error("msr_core: bad GRANULE_BITS");
    end

    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_BUS, S_REFETCH, S_DONE} msr_state_e;
    msr_state_e state, next_state;

    logic [`MSR_TB_DIV_W-1:0] tb_div;
    logic [31:0]              opcode_seen;
    msr_rsp_s                 next_rsp;
    msr_bus_e                 bus_kind;

    // decode; bit 25 (lsb-index 6) masked so both read forms match
    wire [31:0] insn_norm   = insn_word & ~(32'h1 << `MSR_BIT25_POS); // RULE12
    // one-hot operation decode from the carrier
    wire        is_lr       = req.op == MSR_OP_LOAD_RSV;
    wire        is_sc       = req.op == MSR_OP_STORE_COND;
    wire        is_fb       = req.op == MSR_OP_FULL_BAR;
    wire        is_io       = req.op == MSR_OP_IO_BAR;
    wire        is_is       = req.op == MSR_OP_INSN_SYNC;
    wire        is_tb       = req.op == MSR_OP_READ_TB;
    wire        is_blk      = req.op == MSR_OP_BLOCK_CACHE;
    // form and alignment faults, checked before any bus work
    wire        misaligned  = (is_lr | is_sc) & (req.addr[`MSR_WORD_ALIGN_BITS-1:0] != 2'h0); // RULE3
    wire        bad_form    = (is_lr | is_fb) & req.record_bit; // RULE9
    wire        bad_sc      = is_sc & ~req.record_bit; // RULE4
    // write-through never adds an exception here
    wire        wt_ignored  = page_write_through & 1'b0; // RULE2
    // reservation match ignores the offset within the granule
    wire        rsv_hit     = rsv_valid &&
                              (rsv_addr[31:GRANULE_BITS] == req.addr[31:GRANULE_BITS]); // RULE1
    wire        sc_ok       = is_sc & rsv_hit & ~misaligned; // RULE23
    // divider pulse, one clock in four
    wire        tb_pulse    = tb_div == 2'(`MSR_TB_DIV - 1); // RULE11
    wire        start       = req_valid && state == S_IDLE;
    // barrier hold conditions; store queue drain is not among them,
    // so an insn sync never waits on pending stores
    wire        fb_wait     = is_fb & (older_mem_busy | older_excp_pending); // RULE6 RULE7
    wire        io_wait     = is_io & older_io_busy; // RULE14 RULE17
    wire        is_wait     = is_is & (older_incomplete | older_excp_pending); // RULE19 RULE20
    // bus work: every aligned conditional store, broadcasts when enabled
    wire        need_bus    = (is_sc & ~misaligned) | // RULE5
                              ((is_fb | is_io | is_blk) & broadcast_enable_bit); // RULE8 RULE15 RULE22
    // one 32-bit half per read, never the whole 64-bit count
    wire [31:0] tb_read     = req.tb_half ? time_base[63:32] : time_base[31:0]; // RULE10 RULE13
    // bus operation kind for the broadcast or the conditional store
    assign bus_kind = is_sc  ? MSR_BUS_STORE_COND :
                      is_fb  ? MSR_BUS_FULL_BAR   :
                      is_io  ? MSR_BUS_IO_BAR     :
                      is_blk ? MSR_BUS_BLOCK      : MSR_BUS_NONE;

    // sequencer
    // misaligned requests skip the bus and any wait
    // a refused barrier broadcast stays in the bus state and retries
    // refetch takes one cycle after the flush
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:    if (req_valid) next_state = S_WAIT;
            S_WAIT:    if (misaligned || bad_form || !(fb_wait || io_wait || is_wait))
                           next_state = misaligned ? S_DONE : (need_bus ? S_BUS : (is_is ? S_REFETCH : S_DONE));
            S_BUS:     if (bus_ack && (bus_ok || !is_fb)) next_state = S_DONE; // RULE8
            S_REFETCH: next_state = S_DONE; // RULE19
            S_DONE:    next_state = S_IDLE;
            default:   next_state = S_IDLE;
        endcase
    end

    // answer content
    // the cr0 result only means something for a recorded conditional store;
    // bit 1 of the field carries success
    always_comb begin
        next_rsp                      = '0;
        next_rsp.align_exc            = misaligned & ~wt_ignored;
        next_rsp.invalid_form         = bad_form | bad_sc; // RULE4 RULE9
        next_rsp.cr0_valid            = is_sc & req.record_bit & ~misaligned;
        next_rsp.condition_field_zero = {2'h0, sc_ok, 1'b0}; // RULE23
        next_rsp.data                 = is_tb ? tb_read : (is_lr ? load_data : 32'h0);
    end

    always_ff @(posedge clock) begin
        if (!nrst) state <= S_IDLE;
        else       state <= next_state;
    end

    // response register loaded on every wait cycle
    // rsp is held after done, so the pipeline may sample it late
    always_ff @(posedge clock) begin
        if (!nrst)                 rsp <= '0;
        else if (state == S_WAIT)  rsp <= next_rsp;
    end

    // reservation: set by reserved load, dropped by every aligned conditional store
    // a misaligned request or a reserve with the record bit leaves the reservation untouched
    // a failing conditional store still clears it
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rsv_valid <= 1'b0;
            rsv_addr  <= 32'h0;
        end else if (state == S_WAIT && next_state != S_WAIT && !misaligned) begin
            if (is_lr && !bad_form) begin
                rsv_valid <= 1'b1; // RULE1
                rsv_addr  <= {req.addr[31:GRANULE_BITS], GRANULE_BITS'(0)};
            end else if (is_sc) begin
                rsv_valid <= 1'b0; // RULE23
            end
        end
    end

    // time base counter, one tick each fourth clock
    // the divider runs freely from reset, so ticks are evenly spaced
    // a 64-bit count does not wrap in any useful lifetime
    always_ff @(posedge clock) begin
        if (!nrst) begin
            tb_div    <= '0;
            time_base <= 64'h0;
        end else begin
            tb_div <= tb_div + 2'h1;
            if (tb_pulse) time_base <= time_base + 64'h1; // RULE11
        end
    end

    // opcode seen, kept for trace
    // nothing decodes it further; both read forms look alike here
    always_ff @(posedge clock) begin
        if (!nrst)      opcode_seen <= 32'h0;
        else if (start) opcode_seen <= insn_norm;
    end

    // bus request
    // loaded in the wait state, so it stands still while bus_valid is up
    // store data goes out only with a live reservation
    always_ff @(posedge clock) begin
        if (!nrst) bus_req <= '0;
        else if (state == S_WAIT) begin
            bus_req.kind      <= bus_kind;
            bus_req.addr      <= req.addr;
            bus_req.data      <= sc_ok ? req.store_data : 32'h0;
            bus_req.bypass_l2 <= is_io; // RULE16
        end
    end

    // handshake and pipeline controls
    // stall and gather block cover the whole request, done cycle included
    // the io barrier blocks gathering but does not stall younger work
    // iq_flush stands for the whole wait of an insn sync
    assign bus_valid     = state == S_BUS;
    assign done          = state == S_DONE;
    assign stall_younger = state != S_IDLE && (is_fb || is_is); // RULE6 RULE19
    assign gather_block  = store_gather_en && state != S_IDLE && (is_fb || is_io); // RULE6 RULE18
    assign iq_flush      = state == S_WAIT && is_is; // RULE19
    assign refetch       = state == S_REFETCH;

    // checks: each guards one rule at the logic that carries it out
    // the antecedents name the state, except in the time base tick and step, trace, refetch, reservation alignment, io bypass and bus hold checks
    // all run on the one clock and are off while reset is low
    AST_TB_QUARTER: assert property (@(posedge clock) disable iff (!nrst) // RULE11
        tb_pulse |=> !tb_pulse [*3]) else $error("time base ticks too often");
    AST_TB_STEP: assert property (@(posedge clock) disable iff (!nrst) // RULE11
        $past(tb_pulse) && $past(nrst) |-> time_base == $past(time_base) + 64'h1)
        else $error("time base step wrong");
    AST_SC_BUS: assert property (@(posedge clock) disable iff (!nrst) // RULE5
        state == S_WAIT && is_sc && !misaligned && next_state == S_BUS |=> bus_valid && bus_req.kind == MSR_BUS_STORE_COND)
        else $error("store conditional without bus cycle");
    AST_FB_WAIT: assert property (@(posedge clock) disable iff (!nrst) // RULE7
        state == S_WAIT && is_fb && !bad_form && older_mem_busy |=> state == S_WAIT)
        else $error("barrier passed busy memory");
    AST_FB_BCAST: assert property (@(posedge clock) disable iff (!nrst) // RULE8
        state == S_BUS && is_fb && !(bus_ack && bus_ok) |=> state == S_BUS)
        else $error("barrier done without broadcast");
    AST_IO_NOBC: assert property (@(posedge clock) disable iff (!nrst) // RULE15
        state == S_WAIT && is_io && !broadcast_enable_bit && next_state != S_WAIT |=> state == S_DONE)
        else $error("io barrier broadcast while disabled");
    AST_ALIGN: assert property (@(posedge clock) disable iff (!nrst) // RULE3
        state == S_WAIT && misaligned |=> state == S_DONE && rsp.align_exc)
        else $error("misaligned access not flagged");
    AST_SC_CLEAR: assert property (@(posedge clock) disable iff (!nrst) // RULE23
        state == S_WAIT && is_sc && !misaligned && next_state != S_WAIT |=> !rsv_valid)
        else $error("reservation kept after conditional store");
    AST_IS_FLUSH: assert property (@(posedge clock) disable iff (!nrst) // RULE19
        refetch |-> $past(state) == S_WAIT && $past(iq_flush))
        else $error("refetch without flush");
    AST_GATHER: assert property (@(posedge clock) disable iff (!nrst) // RULE18
        store_gather_en && state == S_WAIT && is_io |-> gather_block)
        else $error("gathering across io barrier");

    // the traced opcode never carries bit 25
    AST_BIT25: assert property (@(posedge clock) disable iff (!nrst) // RULE12
        opcode_seen[`MSR_BIT25_POS] == 1'b0) else $error("bit 25 reached the decoder");

    // the io barrier goes around the second-level cache
    AST_IO_BYPASS: assert property (@(posedge clock) disable iff (!nrst) // RULE16
        bus_valid && bus_req.kind == MSR_BUS_IO_BAR |-> bus_req.bypass_l2) else $error("io barrier sent via cache");

    // the io barrier waits for older uncached or write-through work
    AST_IO_WAIT: assert property (@(posedge clock) disable iff (!nrst) // RULE14
        state == S_WAIT && is_io && older_io_busy |=> state == S_WAIT) else $error("io barrier passed busy io");

    // with broadcast on, the io barrier becomes a bus operation
    AST_IO_BC: assert property (@(posedge clock) disable iff (!nrst) // RULE15
        state == S_WAIT && is_io && broadcast_enable_bit && !older_io_busy |=> bus_valid && bus_req.kind == MSR_BUS_IO_BAR)
        else $error("io barrier not broadcast");

    // insn sync holds while older work may still fault or complete
    AST_IS_WAIT: assert property (@(posedge clock) disable iff (!nrst) // RULE19
        state == S_WAIT && is_is && (older_incomplete || older_excp_pending) |=> state == S_WAIT)
        else $error("insn sync passed older work");

    // insn sync goes on although stores are still pending
    AST_IS_NOSTQ: assert property (@(posedge clock) disable iff (!nrst) // RULE20
        state == S_WAIT && is_is && !older_incomplete && !older_excp_pending |=> state == S_REFETCH)
        else $error("insn sync waited on the store queue");

    // barrier or reserve with the record bit is an invalid form
    AST_FORM: assert property (@(posedge clock) disable iff (!nrst) // RULE9
        state == S_WAIT && bad_form |=> rsp.invalid_form) else $error("invalid form not flagged");

    // conditional store without the record bit leaves the field undefined
    AST_SC_FORM: assert property (@(posedge clock) disable iff (!nrst) // RULE4
        state == S_WAIT && is_sc && !req.record_bit |=> rsp.invalid_form && !rsp.cr0_valid)
        else $error("unrecorded store conditional accepted");

    // block cache operations are broadcast when enabled
    AST_BLK_BC: assert property (@(posedge clock) disable iff (!nrst) // RULE22
        state == S_WAIT && is_blk && broadcast_enable_bit |=> bus_valid && bus_req.kind == MSR_BUS_BLOCK)
        else $error("block operation not broadcast");

    // a held reservation always names the start of a granule
    AST_RSV_ALIGN: assert property (@(posedge clock) disable iff (!nrst) // RULE1
        rsv_valid |-> rsv_addr[GRANULE_BITS-1:0] == '0) else $error("reservation not granule aligned");

    // a write-through page adds no fault of its own
    AST_WT: assert property (@(posedge clock) disable iff (!nrst) // RULE2
        state == S_WAIT && page_write_through && !misaligned && next_state != S_WAIT |=> !rsp.align_exc)
        else $error("write-through page faulted");

    // the upper half read returns the count as it stood
    AST_TB_HIGH: assert property (@(posedge clock) disable iff (!nrst) // RULE10
        state == S_WAIT && is_tb && req.tb_half |=> {32'h0, rsp.data} == ($past(time_base) >> 32))
        else $error("upper time base half wrong");

    // a bus request stands unchanged until acknowledged
    AST_BUS_HOLD: assert property (@(posedge clock) disable iff (!nrst) // RULE5
        bus_valid && !bus_ack |=> bus_valid && $stable(bus_req)) else $error("bus request dropped early");

    // scenario covers
    COV_SC: cover property (@(posedge clock) disable iff (!nrst) state == S_BUS && is_sc && bus_ack);
    COV_IO: cover property (@(posedge clock) disable iff (!nrst) bus_valid && bus_req.kind == MSR_BUS_IO_BAR && bus_ack);
    COV_FB: cover property (@(posedge clock) disable iff (!nrst) state == S_BUS && is_fb && bus_ack && bus_ok);
    COV_IS: cover property (@(posedge clock) disable iff (!nrst) refetch);
    COV_TB: cover property (@(posedge clock) disable iff (!nrst) done && is_tb);
endmodule
`default_nettype wire

// [tb/msr_bus_model.sv]
// Purpose: external bus partner for the memory sync unit bench
// Assumes: one bus request at a time, held until acknowledged
// Notes:   acks after ack_delay cycles, can refuse one full barrier
`timescale 1ns/1ps
`default_nettype none
module msr_bus_model
    import msr_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       nrst,
    // bus from the core
    input  wire logic       bus_valid,
    input  wire msr_bus_s   bus_req,
    output logic            bus_ack,
    output logic            bus_ok,
    // bench control and record
    input  wire logic [3:0] ack_delay,
    input  wire logic       refuse_once,
    output logic [7:0]      txn_count,
    output msr_bus_s        last_req
);
    logic [3:0] wait_c;
    logic       refused;
    wire        is_bar = (bus_req.kind == MSR_BUS_FULL_BAR);
    // queued l2 references drain for ack_delay cycles before the ack
    always @(posedge clock) begin
        if (!nrst) begin
            wait_c    <= 4'h0;
            txn_count <= 8'h00;
            refused   <= 1'b0;
            bus_ack   <= 1'b0;
            bus_ok    <= 1'b0;
            last_req  <= '0;
        end else if (bus_valid && !bus_ack && wait_c == ack_delay) begin
            bus_ack   <= 1'b1;
            bus_ok    <= !(refuse_once && !refused && is_bar);
            refused   <= refused | (refuse_once && is_bar);
            txn_count <= txn_count + 8'h01;
            last_req  <= bus_req;
            wait_c    <= 4'h0;
        end else begin
            bus_ack <= 1'b0;
            bus_ok  <= ~bus_ok; // not held outside the ack cycle
            if (bus_valid && !bus_ack) wait_c <= wait_c + 4'h1;
        end
    end
endmodule
`default_nettype wire

// [tb/memory_sync_reservation_unit_tb.sv]
// Purpose: self-checking bench for msr_core
// Assumes: msr_bus_model stands on the bus side
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module memory_sync_reservation_unit_tb
    import msr_pkg::*;
;
    logic        clock = 1'b0, nrst = 1'b0, req_valid = 1'b0, user_mode = 1'b1, page_write_through = 1'b0;
    logic        older_excp_pending = 1'b0, older_mem_busy = 1'b0, older_io_busy = 1'b0, older_incomplete = 1'b0;
    logic        broadcast_enable_bit = 1'b0, store_gather_en = 1'b1, refuse_once = 1'b0;
    logic [31:0] insn_word = 32'h0, load_data = 32'hcafe_0042, rsv_addr;
    logic [3:0]  ack_delay = 4'h0;
    msr_req_s    req = '0;
    msr_rsp_s    rsp, got;
    logic        done, stall_younger, gather_block, iq_flush, refetch, rsv_valid, bus_valid, bus_ack, bus_ok;
    logic [63:0] time_base, tb0;
    msr_bus_s    bus_req, last_req;
    logic [7:0]  txn_count, t0;
    int          bad_count = 0, checked = 0, lat, flushes = 0, refetches = 0;
    msr_op_e     ops[3] = '{MSR_OP_FULL_BAR, MSR_OP_IO_BAR, MSR_OP_BLOCK_CACHE};
    msr_bus_e    kinds[3] = '{MSR_BUS_FULL_BAR, MSR_BUS_IO_BAR, MSR_BUS_BLOCK};
    // 100 ns clock
    always #50 clock = ~clock;
    msr_core dut_u (.clock(clock), .nrst(nrst), .req_valid(req_valid), .req(req), .insn_word(insn_word),
        .user_mode(user_mode), .page_write_through(page_write_through), .older_excp_pending(older_excp_pending),
        .older_mem_busy(older_mem_busy), .older_io_busy(older_io_busy), .older_incomplete(older_incomplete),
        .broadcast_enable_bit(broadcast_enable_bit), .store_gather_en(store_gather_en), .load_data(load_data),
        .done(done), .rsp(rsp), .stall_younger(stall_younger), .gather_block(gather_block), .iq_flush(iq_flush),
        .refetch(refetch), .rsv_valid(rsv_valid), .rsv_addr(rsv_addr), .time_base(time_base),
        .bus_valid(bus_valid), .bus_req(bus_req), .bus_ack(bus_ack), .bus_ok(bus_ok));
    msr_bus_model bus_u (.clock(clock), .nrst(nrst), .bus_valid(bus_valid), .bus_req(bus_req), .bus_ack(bus_ack),
        .bus_ok(bus_ok), .ack_delay(ack_delay), .refuse_once(refuse_once), .txn_count(txn_count),
        .last_req(last_req));
    // counts flush and refetch cycles over the whole run
    always @(posedge clock) begin
        flushes   <= flushes + (iq_flush === 1'b1);
        refetches <= refetches + (refetch === 1'b1);
    end
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one request held until the done pulse, answer kept in got
    task automatic run(input msr_op_e op, input logic [31:0] a, input logic rb, input logic half);
        @(negedge clock);
        req = '{op, a, rb, half, 32'h1234_abcd};
        req_valid = 1'b1;
        lat = 0;
        do begin
            @(negedge clock);
            lat++;
        end while (done !== 1'b1 && lat < 300);
        if (lat >= 300) bad_count++;
        got = rsp;
        @(negedge clock);
        req_valid = 1'b0;
    endtask
    task automatic summarize;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clock);
        bad_count++;
        summarize();
    end
    initial begin
        repeat (4) @(negedge clock);
        nrst = 1'b1;
        tb0 = time_base;
        repeat (8) @(negedge clock);
        chk(time_base - tb0, 64'h2);
        run(MSR_OP_READ_TB, 32'h0, 1'b0, 1'b1);
        chk(got.data, 32'h0);
        tb0 = time_base;
        insn_word = 32'h0000_0040;
        run(MSR_OP_READ_TB, 32'h0, 1'b0, 1'b0);
        chk(got.data <= time_base[31:0] && got.data >= tb0[31:0], 1'b1);
        $display("time base test over");
        page_write_through = 1'b1;
        run(MSR_OP_LOAD_RSV, 32'h0000_1104, 1'b0, 1'b0);
        chk({got.data, got.align_exc}, {32'hcafe_0042, 1'b0});
        chk({rsv_valid, rsv_addr}, {1'b1, 32'h0000_1100});
        t0 = txn_count;
        run(MSR_OP_STORE_COND, 32'h0000_111c, 1'b1, 1'b0);
        chk({got.condition_field_zero[1], got.invalid_form, rsv_valid, got.cr0_valid, txn_count - t0}, {4'b1001, 8'h1});
        chk(last_req.kind, MSR_BUS_STORE_COND);
        run(MSR_OP_STORE_COND, 32'h0000_111c, 1'b1, 1'b0);
        chk({got.condition_field_zero[1], txn_count - t0}, {1'b0, 8'h2});
        run(MSR_OP_LOAD_RSV, 32'h0000_1100, 1'b0, 1'b0);
        run(MSR_OP_STORE_COND, 32'h0000_1120, 1'b1, 1'b0);
        chk({got.condition_field_zero[1], rsv_valid}, 2'b00);
        t0 = txn_count;
        run(MSR_OP_LOAD_RSV, 32'h0000_1102, 1'b0, 1'b0);
        chk({got.align_exc, rsv_valid}, 2'b10);
        run(MSR_OP_STORE_COND, 32'h0000_1101, 1'b1, 1'b0);
        chk({got.align_exc, txn_count - t0}, {1'b1, 8'h0});
        run(MSR_OP_LOAD_RSV, 32'h0000_1100, 1'b1, 1'b0);
        chk(got.invalid_form, 1'b1);
        run(MSR_OP_FULL_BAR, 32'h0, 1'b1, 1'b0);
        chk(got.invalid_form, 1'b1);
        run(MSR_OP_STORE_COND, 32'h0000_1100, 1'b0, 1'b0);
        chk({got.invalid_form, got.cr0_valid}, 2'b10);
        $display("reservation test over");
        ack_delay = 4'h5;
        for (int b = 0; b < 2; b++) begin
            broadcast_enable_bit = b[0];
            foreach (ops[i]) begin
                t0 = txn_count;
                run(ops[i], 32'h0000_2000, 1'b0, 1'b0);
                chk(txn_count - t0, b);
                if (b == 1) chk(last_req.kind, kinds[i]);
                if (b == 1 && i == 1) chk(last_req.bypass_l2, 1'b1);
            end
        end
        refuse_once = 1'b1;
        t0 = txn_count;
        run(MSR_OP_FULL_BAR, 32'h0, 1'b0, 1'b0);
        chk(txn_count - t0, 8'h2);
        refuse_once = 1'b0;
        $display("broadcast test over");
        ack_delay = 4'h0;
        for (int k = 0; k < 3; k++) begin
            fork
                run(k == 2 ? MSR_OP_IO_BAR : MSR_OP_FULL_BAR, 32'h0, 1'b0, 1'b0);
                begin
                    {older_excp_pending, older_mem_busy, older_io_busy} = 3'b100 >> k;
                    repeat (6) @(negedge clock);
                    if (k < 2) chk({stall_younger, gather_block}, 2'b11);
                    else chk({stall_younger, gather_block}, 2'b01);
                    {older_excp_pending, older_mem_busy, older_io_busy} = 3'b000;
                end
            join
            chk(lat > 6, 1'b1);
        end
        $display("barrier wait test over");
        {older_mem_busy, older_incomplete, older_excp_pending} = 3'b111;
        fork
            run(MSR_OP_INSN_SYNC, 32'h0, 1'b0, 1'b0);
            begin
                repeat (5) @(negedge clock);
                {older_incomplete, older_excp_pending} = 2'b00;
            end
        join
        chk({lat > 5, lat < 40, flushes > 0, refetches}, {3'b111, 32'd1});
        older_mem_busy = 1'b0;
        $display("insn sync test over");
        summarize();
    end
endmodule
`default_nettype wire
